// [src/irq_sleep_ctrl.sv]
// Interrupt controller with light and deep sleep control, Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module irq_sleep_ctrl (
	input wire logic core_clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [irq_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [1:0] response,
	// Request sources
	input wire logic ext_irq0_pin,
	input wire logic ext_irq1_pin,
	input wire logic timer0_ovf,
	input wire logic timer1_ovf,
	input wire logic timer2_ovf,
	input wire logic serial_irq,
	input wire logic ext_code_mem,
	// Processor core
	input wire logic irq_ack,
	input wire logic irq_ret,
	output logic irq_req,
	output logic [2:0] irq_vector,
	output logic [1:0] irq_level,
	// Power control
	output logic core_clk_en,
	output logic osc_run,
	output logic strobe_hold_en,
	output logic strobe_hold_level,
	output logic port0_float,
	output logic port2_addr_keep
);
	localparam int NS = irq_pkg::NUM_SRC;

	// ************************************************************
	// Registers and state
	// ************************************************************
	logic [7:0] ie_reg, prio_high_reg, prio_low_reg, power_control_reg_reg, ext_mode_reg;
	logic [7:0] power_control_reg_next;
	logic [3:0] in_service_reg, in_service_next;
	irq_pkg::sleep_state_t state_reg, state_next;
	logic [1:0] pin_meta_reg, pin_sync_reg, pin_prev_reg, ext_flag_reg;
	logic code_meta_reg, code_sync_reg;
	logic waitrequest_reg, irq_req_reg;
	logic [31:0] readdata_reg;
	logic [1:0] response_reg, irq_level_reg;
	logic [2:0] irq_vector_reg;
	logic core_clk_en_reg, osc_run_reg, strobe_hold_en_reg, strobe_hold_level_reg;
	logic port0_float_reg, port2_addr_keep_reg;

	// ************************************************************
	// Pin synchronisers and external request flags
	// ************************************************************
	logic [1:0] pin_raw, pin_fall, pin_rise, wake_en, wake_low, wake_release, ext_req;
	logic [1:0] ext_ack;
	assign pin_raw = {ext_irq1_pin, ext_irq0_pin};
	assign pin_fall = pin_prev_reg & ~pin_sync_reg;
	assign pin_rise = ~pin_prev_reg & pin_sync_reg;
	assign wake_en = {ie_reg[irq_pkg::SRC_EXT1], ie_reg[irq_pkg::SRC_EXT0]} & {2{ie_reg[irq_pkg::GLOBAL_EN_BIT]}};
	assign wake_low = wake_en & ~pin_sync_reg;
	assign wake_release = (state_reg == irq_pkg::SLEEP_WAKE) ? (wake_en & pin_rise) : 2'b00;
	assign ext_ack[0] = irq_ack && irq_vector_reg == 3'(irq_pkg::SRC_EXT0);
	assign ext_ack[1] = irq_ack && irq_vector_reg == 3'(irq_pkg::SRC_EXT1);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					pin_meta_reg[gi] <= 1'b1;
					pin_sync_reg[gi] <= 1'b1;
					pin_prev_reg[gi] <= 1'b1;
					ext_flag_reg[gi] <= 1'b0;
				end else begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_sync_reg[gi] <= pin_meta_reg[gi];
					pin_prev_reg[gi] <= pin_sync_reg[gi];
					// Set wins over the acknowledge clear; a wake release also latches the request
					if ((ext_mode_reg[gi] && pin_fall[gi]) || wake_release[gi]) begin
						ext_flag_reg[gi] <= 1'b1;
					end else if (ext_ack[gi]) begin
						ext_flag_reg[gi] <= 1'b0;
					end
				end
			end
			// Level mode requests while the pin stays low
			assign ext_req[gi] = ext_flag_reg[gi] | (~ext_mode_reg[gi] & ~pin_sync_reg[gi]);
		end
	endgenerate

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			code_meta_reg <= 1'b0;
			code_sync_reg <= 1'b0;
		end else begin
			code_meta_reg <= ext_code_mem;
			code_sync_reg <= code_meta_reg;
		end
	end

	// ************************************************************
	// Arbitration
	// ************************************************************
	logic [NS-1:0] src_pending;
	irq_pkg::irq_pick_t pick;
	irq_pkg::svc_t active;
	assign src_pending = {timer2_ovf, serial_irq, timer1_ovf, ext_req[1], timer0_ovf, ext_req[0]};
	assign active = irq_pkg::top_active(in_service_reg);

	irq_arbiter #(.NUM_SRC(NS)) u_arbiter (
		.src_pending(src_pending),
		.src_enable(ie_reg[NS-1:0]),
		.global_enable(ie_reg[irq_pkg::GLOBAL_EN_BIT]),
		.prio_high(prio_high_reg[NS-1:0]),
		.prio_low(prio_low_reg[NS-1:0]),
		.in_service(in_service_reg),
		.pick(pick)
	);

	// Nothing is offered while powered down, nor in the cycle the core takes a vector
	logic irq_req_next, asleep_deep;
	assign asleep_deep = state_reg == irq_pkg::SLEEP_DEEP || state_reg == irq_pkg::SLEEP_WAKE;
	assign irq_req_next = pick.valid && !asleep_deep && !irq_ack;

	// Nesting: acknowledge marks a level busy, return frees the top one
	always_comb begin
		in_service_next = in_service_reg;
		if (irq_ret && active.any) begin
			in_service_next[active.level] = 1'b0;
		end
		if (irq_ack && irq_req_reg) begin
			in_service_next[irq_level_reg] = 1'b1;
		end
	end

	// ************************************************************
	// Register bus
	// ************************************************************
	logic [7:0] reg_idx, rd_byte, wr_byte;
	logic bus_req, bus_commit, aligned, hit_ie, hit_ph, hit_pl, hit_pc, hit_em, hit_st, mapped, wr_ok;
	assign reg_idx = address[irq_pkg::ADDR_W-1:2];
	assign aligned = address[1:0] == 2'b00;
	assign bus_req = read || write;
	assign bus_commit = bus_req && !waitrequest_reg;
	assign hit_ie = aligned && reg_idx == irq_pkg::IDX_IRQ_ENABLE;
	assign hit_ph = aligned && reg_idx == irq_pkg::IDX_PRIO_HIGH;
	assign hit_pl = aligned && reg_idx == irq_pkg::IDX_PRIO_LOW;
	assign hit_pc = aligned && reg_idx == irq_pkg::IDX_POWER_CTRL;
	assign hit_em = aligned && reg_idx == irq_pkg::IDX_EXT_MODE;
	assign hit_st = aligned && reg_idx == irq_pkg::IDX_IRQ_STATUS;
	assign mapped = hit_ie | hit_ph | hit_pl | hit_pc | hit_em | hit_st;
	assign wr_ok = bus_commit && write && byteenable[0];
	assign wr_byte = writedata[7:0];
	// Reserved bits read as zero
	assign rd_byte = hit_ie ? ie_reg :
		hit_ph ? prio_high_reg :
		hit_pl ? prio_low_reg :
		hit_pc ? power_control_reg_reg :
		hit_em ? ext_mode_reg :
		hit_st ? {1'b0, irq_req_reg, state_reg, in_service_reg} : 8'h00;

	// ************************************************************
	// Sleep control
	// ************************************************************
	logic wr_power_control_reg, sleep_enter, both_bits;
	assign wr_power_control_reg = wr_ok && hit_pc;
	assign sleep_enter = wr_power_control_reg && state_reg == irq_pkg::SLEEP_RUN
		&& (wr_byte[irq_pkg::DEEP_BIT] || wr_byte[irq_pkg::LIGHT_BIT]);
	assign both_bits = power_control_reg_reg[irq_pkg::DEEP_BIT] && power_control_reg_reg[irq_pkg::LIGHT_BIT];

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			irq_pkg::SLEEP_RUN: begin
				if (sleep_enter) begin
					// Deep sleep takes over when both bits are written
					state_next = wr_byte[irq_pkg::DEEP_BIT] ? irq_pkg::SLEEP_DEEP : irq_pkg::SLEEP_LIGHT;
				end
			end
			irq_pkg::SLEEP_LIGHT: begin
				if (pick.valid) begin
					state_next = irq_pkg::SLEEP_RUN;
				end
			end
			irq_pkg::SLEEP_DEEP: begin
				if (|wake_low) begin
					state_next = irq_pkg::SLEEP_WAKE;
				end
			end
			irq_pkg::SLEEP_WAKE: begin
				if (|wake_release) begin
					state_next = irq_pkg::SLEEP_RUN;
				end
			end
			default: state_next = irq_pkg::SLEEP_RUN;
		endcase
	end

	always_comb begin
		power_control_reg_next = power_control_reg_reg;
		if (wr_power_control_reg) begin
			power_control_reg_next = wr_byte & irq_pkg::POWER_CONTROL_REG_MASK;
		end
		if (state_reg == irq_pkg::SLEEP_LIGHT && pick.valid) begin
			power_control_reg_next[irq_pkg::LIGHT_BIT] = 1'b0;
		end
		if (irq_ack && irq_req_reg) begin
			power_control_reg_next[irq_pkg::LIGHT_BIT] = 1'b0;
			if (both_bits) begin
				power_control_reg_next[irq_pkg::DEEP_BIT] = 1'b0;
			end
		end
	end

	logic light_next, sleep_next;
	assign light_next = state_next == irq_pkg::SLEEP_LIGHT;
	assign sleep_next = state_next != irq_pkg::SLEEP_RUN;

	// ************************************************************
	// Sequential state
	// ************************************************************
	// Reset clears all of these; a pin wake leaves every register but state_reg as it was
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ie_reg <= irq_pkg::IE_RESET;
			prio_high_reg <= irq_pkg::PRIO_RESET;
			prio_low_reg <= irq_pkg::PRIO_RESET;
			ext_mode_reg <= irq_pkg::EXT_MODE_RESET;
			power_control_reg_reg <= irq_pkg::POWER_CONTROL_REG_RESET;
			state_reg <= irq_pkg::SLEEP_RUN;
			in_service_reg <= '0;
		end else begin
			if (wr_ok && hit_ie) ie_reg <= wr_byte & irq_pkg::IE_MASK;
			if (wr_ok && hit_ph) prio_high_reg <= wr_byte & irq_pkg::PRIO_MASK;
			if (wr_ok && hit_pl) prio_low_reg <= wr_byte & irq_pkg::PRIO_MASK;
			if (wr_ok && hit_em) ext_mode_reg <= wr_byte & irq_pkg::EXT_MODE_MASK;
			power_control_reg_reg <= power_control_reg_next;
			state_reg <= state_next;
			in_service_reg <= in_service_next;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			waitrequest_reg <= 1'b1;
			readdata_reg <= '0;
			response_reg <= irq_pkg::RESP_OK;
		end else begin
			// One wait cycle: data is captured, then the request completes
			waitrequest_reg <= !(bus_req && waitrequest_reg);
			readdata_reg <= {24'h000000, rd_byte};
			response_reg <= mapped ? irq_pkg::RESP_OK : irq_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_req_reg <= 1'b0;
			irq_vector_reg <= '0;
			irq_level_reg <= '0;
		end else begin
			irq_req_reg <= irq_req_next;
			irq_vector_reg <= pick.src;
			irq_level_reg <= pick.level;
		end
	end

	// Core clock gating freezes core registers and port latches in place
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			core_clk_en_reg <= 1'b1;
			osc_run_reg <= 1'b1;
			strobe_hold_en_reg <= 1'b0;
			strobe_hold_level_reg <= 1'b0;
			port0_float_reg <= 1'b0;
			port2_addr_keep_reg <= 1'b0;
		end else begin
			core_clk_en_reg <= !sleep_next;
			osc_run_reg <= state_next != irq_pkg::SLEEP_DEEP;
			strobe_hold_en_reg <= sleep_next;
			strobe_hold_level_reg <= light_next;
			port0_float_reg <= sleep_next && code_sync_reg;
			port2_addr_keep_reg <= light_next && code_sync_reg;
		end
	end

	assign readdata = readdata_reg;
	assign waitrequest = waitrequest_reg;
	assign response = response_reg;
	assign irq_req = irq_req_reg;
	assign irq_vector = irq_vector_reg;
	assign irq_level = irq_level_reg;
	assign core_clk_en = core_clk_en_reg;
	assign osc_run = osc_run_reg;
	assign strobe_hold_en = strobe_hold_en_reg;
	assign strobe_hold_level = strobe_hold_level_reg;
	assign port0_float = port0_float_reg;
	assign port2_addr_keep = port2_addr_keep_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	logic [7:0] ie_d_reg, ph_d_reg, pl_d_reg;
	logic [NS-1:0] pend_d_reg;
	logic better_exists;
	always_ff @(posedge core_clk) begin
		ie_d_reg <= ie_reg;
		ph_d_reg <= prio_high_reg;
		pl_d_reg <= prio_low_reg;
		pend_d_reg <= src_pending;
	end
	always_comb begin
		better_exists = 1'b0;
		for (int j = 0; j < NS; j++) begin
			if (pend_d_reg[j] && ie_d_reg[j] && ({ph_d_reg[j], pl_d_reg[j]} > irq_level_reg
				|| ({ph_d_reg[j], pl_d_reg[j]} == irq_level_reg && 3'(j) < irq_vector_reg))) begin
				better_exists = 1'b1;
			end
		end
	end

	sequence seq_deep_wake;
		state_reg == irq_pkg::SLEEP_DEEP && (|wake_low);
	endsequence
	sequence seq_oscillator_back;
		state_reg == irq_pkg::SLEEP_WAKE && osc_run_reg && !core_clk_en_reg;
	endsequence

	chk_global_gate: assert property (!ie_reg[7] |=> !irq_req_reg) else $error("request with global gate off");
	chk_source_enable: assert property (irq_req_reg |-> ie_d_reg[irq_vector_reg]
		&& irq_vector_reg < 3'(NS)) else $error("vector of a disabled source");
	chk_level_form: assert property (irq_req_reg
		|-> irq_level_reg == {ph_d_reg[irq_vector_reg], pl_d_reg[irq_vector_reg]}) else $error("level not formed");
	chk_strict_preempt: assert property (irq_req_reg && $past(active.any)
		|-> irq_level_reg > $past(active.level)) else $error("preempted by equal or lower level");
	chk_top_level_hold: assert property ($past(in_service_reg[3]) |-> !irq_req_reg) else $error("level 3 routine preempted");
	chk_best_choice: assert property (irq_req_reg |-> !better_exists) else $error("higher or earlier-polled source skipped");
	chk_light_exit: assert property (state_reg == irq_pkg::SLEEP_LIGHT && pick.valid
		|=> state_reg == irq_pkg::SLEEP_RUN && !power_control_reg_reg[0] && core_clk_en_reg) else $error("light sleep not ended");
	chk_deep_stays: assert property (state_reg == irq_pkg::SLEEP_DEEP && !(|wake_low)
		|=> state_reg == irq_pkg::SLEEP_DEEP && !osc_run_reg && !irq_req_reg) else $error("deep sleep left early");
	chk_wake_start: assert property (seq_deep_wake |=> seq_oscillator_back) else $error("oscillator not restarted");
	chk_both_cleared: assert property (irq_ack && irq_req_reg && both_bits && !wr_power_control_reg
		|=> power_control_reg_reg[1:0] == 2'b00) else $error("sleep bits not cleared on vectoring");
	chk_sleep_strobes: assert property (state_reg != irq_pkg::SLEEP_RUN
		|-> strobe_hold_en_reg && !core_clk_en_reg && strobe_hold_level_reg == (state_reg == irq_pkg::SLEEP_LIGHT))
		else $error("strobe levels wrong in sleep");
endmodule
`default_nettype wire

// [src/irq_pkg.sv]
// Constants, types and shared decoding of the six-source interrupt and sleep controller
// How it works
// - Six sources: two external pins, timers 0, 1, 2 overflow, serial port.
// - Enable bit 7 gates all sources; when set, each own bit gates.
// - Enable layout: 5 timer2, 4 serial, 3 timer1, 2 ext1, 1 timer0, 0 ext0.
// - Level is {high bit, low bit}; 00 lowest, 11 highest.
// - Low priority register uses the enable layout; bits 7 and 6 reserved.
// - High priority register same layout; supplies the upper level bit.
// - Running routine is preempted only by a strictly higher level.
// - A level 3 routine is never preempted until it returns.
// - Simultaneous requests of different levels: higher level is vectored.
// - Same level: fixed polling order picks the winner.
// - Light sleep write is the last instruction; core clock gated, rest runs.
// - In light sleep core state and port levels are held.
// - Any enabled interrupt clears light sleep and is serviced, then code resumes.
// - Deep sleep write is the last instruction; oscillator stops; state retained.
// - Deep sleep ends only by reset or enabled external pin 0 or 1.
// - Low on an enabled wake pin restarts oscillator; return high completes exit.
// - Both wake pins: either low restarts; first release exits; higher level first.
// - After the wake routine returns, code resumes after the deep sleep write.
// - Reset exit reinitialises registers; pin exit keeps them; RAM unchanged.
// - Both sleep bits set: deep exit applies; vectoring clears both bits.
// - Strobes 1 in light, 0 in deep; external code: port0 floats, port2 address light only.
// - Deep bit is bit 1, reset clears it; light bit is bit 0, cleared by interrupt or reset.
package irq_pkg;

	localparam int NUM_SRC = 6;
	localparam int NUM_LEVELS = 4;
	localparam int ADDR_W = 10;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'hA8;
	localparam logic [7:0] IDX_PRIO_HIGH = 8'hB7;
	localparam logic [7:0] IDX_PRIO_LOW = 8'hB8;
	localparam logic [7:0] IDX_POWER_CTRL = 8'h87;
	localparam logic [7:0] IDX_EXT_MODE = 8'hC0;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hC1;

	// Field positions
	localparam int GLOBAL_EN_BIT = 7;
	localparam int SRC_EXT0 = 0;
	localparam int SRC_TMR0 = 1;
	localparam int SRC_EXT1 = 2;
	localparam int SRC_TMR1 = 3;
	localparam int SRC_SERIAL = 4;
	localparam int SRC_TMR2 = 5;
	localparam int DEEP_BIT = 1;
	localparam int LIGHT_BIT = 0;

	// Writable masks and reset values
	localparam logic [7:0] IE_MASK = 8'hBF;
	localparam logic [7:0] PRIO_MASK = 8'h3F;
	localparam logic [7:0] POWER_CONTROL_REG_MASK = 8'h0F;
	localparam logic [7:0] EXT_MODE_MASK = 8'h03;
	localparam logic [7:0] IE_RESET = 8'h00;
	localparam logic [7:0] PRIO_RESET = 8'h00;
	localparam logic [7:0] POWER_CONTROL_REG_RESET = 8'h00;
	localparam logic [7:0] EXT_MODE_RESET = 8'h00;

	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SLEEP_RUN = 2'b00,
		SLEEP_LIGHT = 2'b01,
		SLEEP_DEEP = 2'b10,
		SLEEP_WAKE = 2'b11
	} sleep_state_t;

	typedef struct packed {
		logic valid;
		logic [2:0] src;
		logic [1:0] level;
	} irq_pick_t;

	typedef struct packed {
		logic any;
		logic [1:0] level;
	} svc_t;

	// Highest level currently in service
	function automatic svc_t top_active(input logic [NUM_LEVELS-1:0] in_service);
		svc_t r;
		r = '0;
		for (int i = 0; i < NUM_LEVELS; i++) begin
			if (in_service[i]) begin
				r.any = 1'b1;
				r.level = 2'(i);
			end
		end
		return r;
	endfunction

endpackage

// [src/irq_arbiter.sv]
// Level and polling arbiter for the six interrupt sources
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter #(
	parameter int NUM_SRC = irq_pkg::NUM_SRC
) (
	input wire logic [NUM_SRC-1:0] src_pending,
	input wire logic [NUM_SRC-1:0] src_enable,
	input wire logic global_enable,
	input wire logic [NUM_SRC-1:0] prio_high,
	input wire logic [NUM_SRC-1:0] prio_low,
	input wire logic [irq_pkg::NUM_LEVELS-1:0] in_service,
	output irq_pkg::irq_pick_t pick
);
	logic [NUM_SRC-1:0] live;
	irq_pkg::svc_t active;
	irq_pkg::irq_pick_t best;

	assign live = src_pending & src_enable & {NUM_SRC{global_enable}};
	assign active = irq_pkg::top_active(in_service);

	// Scan levels from the top, and within a level from the lowest index
	always_comb begin
		best = '0;
		for (int lvl = irq_pkg::NUM_LEVELS - 1; lvl >= 0; lvl--) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				if (!best.valid && live[i] && {prio_high[i], prio_low[i]} == 2'(lvl)) begin
					best.valid = 1'b1;
					best.src = 3'(i);
					best.level = 2'(lvl);
				end
			end
		end
	end

	// Only a strictly higher level may preempt; level 3 has nothing above it
	assign pick.valid = best.valid && (!active.any || best.level > active.level);
	assign pick.src = best.src;
	assign pick.level = best.level;
endmodule
`default_nettype wire

// [bench/core_model.sv]
// Processor core stand-in that takes offered vectors after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic irq_req,
	input wire logic [2:0] irq_vector,
	input wire logic [1:0] irq_level,
	input wire logic [3:0] ack_wait,
	output logic irq_ack,
	output logic [2:0] got_vec,
	output logic [1:0] got_lvl,
	output logic [7:0] acks
);
	logic [3:0] cnt;
	// ************************************************************
	// Acknowledge
	// ************************************************************
	// A slow core lets a better source replace the offer before it is taken
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_ack <= 1'b0;
			cnt <= 4'h0;
			acks <= 8'h00;
			got_vec <= 3'h0;
			got_lvl <= 2'h0;
		end else if (irq_ack) begin
			irq_ack <= 1'b0;
			cnt <= 4'h0;
			acks <= acks + 8'h01;
			got_vec <= irq_vector;
			got_lvl <= irq_level;
		end else if (irq_req) begin
			if (cnt >= ack_wait) irq_ack <= 1'b1;
			else cnt <= cnt + 4'h1;
		end else begin
			cnt <= 4'h0;
		end
	end
endmodule
`default_nettype wire

// [bench/four_level_irq_with_sleep_wake_tb_top.sv]
// Self-checking bench for the interrupt and sleep controller
`timescale 1ns/1ps
`default_nettype none
module four_level_irq_with_sleep_wake_tb_top;
	localparam logic [9:0] ADDR_EN = 10'h2A0;
	localparam logic [9:0] ADDR_PH = 10'h2DC;
	localparam logic [9:0] ADDR_PL = 10'h2E0;
	localparam logic [9:0] ADDR_PWR = 10'h21C;
	localparam logic [9:0] ADDR_EM = 10'h300;
	logic core_clk, sys_rst, read, write, ext_irq0_pin, ext_irq1_pin, timer0_ovf, timer1_ovf, timer2_ovf;
	logic serial_irq, ext_code_mem, irq_ack, irq_ret, irq_req, waitrequest, core_clk_en, osc_run;
	logic strobe_hold_en, strobe_hold_level, port0_float, port2_addr_keep;
	logic [9:0] address;
	logic [31:0] writedata, readdata;
	logic [3:0] aw, be;
	logic [2:0] irq_vector, got_vec;
	logic [1:0] irq_level, got_lvl, response, rs;
	logic [7:0] acks, rd, n;
	logic [5:0] s, h, l, e, x;
	int mismatches, checks_done;
	irq_sleep_ctrl DUT (.core_clk(core_clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
		.response(response), .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin), .timer0_ovf(timer0_ovf),
		.timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .serial_irq(serial_irq), .ext_code_mem(ext_code_mem),
		.irq_ack(irq_ack), .irq_ret(irq_ret), .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
		.core_clk_en(core_clk_en), .osc_run(osc_run), .strobe_hold_en(strobe_hold_en),
		.strobe_hold_level(strobe_hold_level), .port0_float(port0_float), .port2_addr_keep(port2_addr_keep));
	core_model core (.core_clk(core_clk), .sys_rst(sys_rst), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_level(irq_level), .ack_wait(aw), .irq_ack(irq_ack), .got_vec(got_vec), .got_lvl(got_lvl), .acks(acks));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// ************************************************************
	// Tasks
	// ************************************************************
	function automatic logic [5:0] best(input logic [5:0] p, input logic [5:0] hi, input logic [5:0] lo);
		logic [5:0] r;
		r = '0;
		for (int i = 0; i < 6; i++) begin
			if (p[i] && (!r[5] || {hi[i], lo[i]} > r[4:3])) r = {1'b1, hi[i], lo[i], 3'(i)};
		end
		return r;
	endfunction
	function automatic logic sig(input int sel);
		return sel == 0 ? irq_req : (sel == 1 ? osc_run : core_clk_en);
	endfunction
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic hang();
		mismatches++;
		$display("ERROR wait expected done seen timeout");
		tally_and_finish();
	endtask
	task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
		int i;
		@(posedge core_clk);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= {24'h000000, d};
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (waitrequest === 1'b0) break;
		end
		rd = readdata[7:0];
		rs = response;
		write <= 1'b0;
		read <= 1'b0;
		if (i == 50) hang();
	endtask
	task automatic wait_for(input int sel, input logic v);
		int i;
		for (i = 0; i < 300 && sig(sel) !== v; i++) @(negedge core_clk);
		if (i == 300) hang();
	endtask
	task automatic wait_ack(input logic [7:0] t);
		int i;
		for (i = 0; i < 300 && acks !== t; i++) @(negedge core_clk);
		if (i == 300) hang();
	endtask
	task automatic quiet(input int sel, input int c);
		logic seen;
		seen = 1'b0;
		repeat (c) begin
			@(negedge core_clk);
			seen = seen | sig(sel);
		end
		chk("stays low", 8'h00, 8'(seen));
	endtask
	// Sources in poll order; external pins request when low
	task automatic set_src(input logic [5:0] v);
		@(posedge core_clk);
		ext_irq0_pin <= !v[0];
		timer0_ovf <= v[1];
		ext_irq1_pin <= !v[2];
		timer1_ovf <= v[3];
		serial_irq <= v[4];
		timer2_ovf <= v[5];
	endtask
	task automatic do_ret();
		@(posedge core_clk);
		irq_ret <= 1'b1;
		@(posedge core_clk);
		irq_ret <= 1'b0;
	endtask
	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		{sys_rst, ext_irq0_pin, ext_irq1_pin} = 3'b111;
		{read, write, timer0_ovf, timer1_ovf, timer2_ovf, serial_irq, ext_code_mem, irq_ret} = 8'h00;
		address = 10'h000;
		writedata = 32'h00000000;
		aw = 4'h0;
		be = 4'hF;
		mismatches = 0;
		checks_done = 0;
		void'($urandom(32'hB828));
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		bus(0, ADDR_EN, 8'h00);
		chk("enable reset", 8'h00, rd);
		bus(0, ADDR_PH, 8'h00);
		chk("prio high reset", 8'h00, rd);
		bus(0, ADDR_PL, 8'h00);
		chk("prio low reset", 8'h00, rd);
		bus(0, 10'h3FC, 8'h00);
		chk("unmapped response", 8'(irq_pkg::RESP_SLVERR), 8'(rs));
		be <= 4'hE;
		bus(1, ADDR_EN, 8'h81);
		be <= 4'hF;
		bus(0, ADDR_EN, 8'h00);
		chk("lane off write", 8'h00, rd);
		chk("mapped response", 8'(irq_pkg::RESP_OK), 8'(rs));
		$display("test registers done");
		aw <= 4'h4;
		for (int t = 0; t < 40; t++) begin
			{s, h, l, e} = 24'($urandom);
			bus(1, ADDR_EN, {t[0], 1'b0, e});
			bus(0, ADDR_EN, 8'h00);
			chk("enable readback", {t[0], 1'b0, e}, rd);
			bus(1, ADDR_PH, {2'h0, h});
			bus(1, ADDR_PL, {2'h0, l});
			n = acks;
			x = t[0] ? best(s & e, h, l) : 6'h00;
			set_src(s);
			if (x[5]) begin
				wait_ack(n + 8'h01);
				chk("vector", 8'(x[2:0]), 8'(got_vec));
				chk("level", 8'(x[4:3]), 8'(got_lvl));
			end else quiet(0, 10);
			set_src(6'h00);
			repeat (4) @(posedge core_clk);
			if (x[5]) do_ret();
		end
		$display("test arbitration done");
		aw <= 4'h0;
		bus(1, ADDR_EN, 8'hBF);
		bus(1, ADDR_PH, 8'h34);
		bus(1, ADDR_PL, 8'h2E);
		n = acks;
		set_src(6'h02);
		wait_ack(n + 8'h01);
		set_src(6'h0A);
		quiet(0, 10);
		set_src(6'h1A);
		wait_ack(n + 8'h02);
		chk("preempt vector", 8'h04, 8'(got_vec));
		set_src(6'h3A);
		wait_ack(n + 8'h03);
		chk("preempt vector", 8'h05, 8'(got_vec));
		set_src(6'h3E);
		quiet(0, 10);
		set_src(6'h08);
		repeat (4) @(posedge core_clk);
		repeat (3) do_ret();
		wait_ack(n + 8'h04);
		chk("after return vector", 8'h03, 8'(got_vec));
		set_src(6'h00);
		repeat (4) @(posedge core_clk);
		do_ret();
		$display("test nesting done");
		ext_code_mem <= 1'b1;
		bus(1, ADDR_EN, 8'h82);
		bus(1, ADDR_PWR, 8'h01);
		@(negedge core_clk);
		chk("light outputs", 8'h1F, {2'h0, core_clk_en, osc_run, strobe_hold_en, strobe_hold_level,
			port0_float, port2_addr_keep});
		n = acks;
		set_src(6'h02);
		wait_for(2, 1'b1);
		wait_ack(n + 8'h01);
		chk("light vector", 8'h01, 8'(got_vec));
		bus(0, ADDR_PWR, 8'h00);
		chk("light bit cleared", 8'h00, rd);
		set_src(6'h00);
		repeat (4) @(posedge core_clk);
		do_ret();
		$display("test light sleep done");
		for (int k = 0; k < 2; k++) begin
			bus(1, ADDR_EN, 8'h87);
			bus(1, ADDR_EM, k ? 8'h03 : 8'h00);
			bus(1, ADDR_PWR, k ? 8'h03 : 8'h02);
			@(negedge core_clk);
			chk("deep outputs", 8'h0A, {2'h0, core_clk_en, osc_run, strobe_hold_en, strobe_hold_level,
				port0_float, port2_addr_keep});
			set_src(6'h02);
			quiet(1, 20);
			n = acks;
			set_src(k ? 6'h05 : 6'h01);
			wait_for(1, 1'b1);
			chk("clock held in wake", 8'h00, 8'(core_clk_en));
			repeat (10) @(posedge core_clk);
			set_src(k ? 6'h01 : 6'h00);
			wait_for(2, 1'b1);
			wait_ack(n + 8'h01);
			chk("wake vector", k ? 8'h02 : 8'h00, 8'(got_vec));
			bus(0, ADDR_EN, 8'h00);
			chk("enable kept", 8'h87, rd);
			bus(0, ADDR_PWR, 8'h00);
			chk("power bits", k ? 8'h00 : 8'h02, rd);
			set_src(6'h00);
			repeat (4) @(posedge core_clk);
			do_ret();
			if (k) begin
				wait_ack(n + 8'h02);
				chk("later wake vector", 8'h00, 8'(got_vec));
				do_ret();
			end
		end
		$display("test deep sleep done");
		bus(1, ADDR_PWR, 8'h02);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		chk("wake by reset", 8'h03, {6'h00, core_clk_en, osc_run});
		bus(0, ADDR_EN, 8'h00);
		chk("enable after reset", 8'h00, rd);
		bus(0, ADDR_PWR, 8'h00);
		chk("power after reset", 8'h00, rd);
		$display("test reset exit done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
